// [src/txb_dev_end.sv]
// Device end: decodes command words and strips offset and end padding
// Function
// - Irq bit set: pulse buffer-done after loading
// - Bits 25:24 select 4/16/32-byte end alignment
// - Host pads buffer end to alignment boundary
// - Device discards host padding dwords
// - Host writes zero to reserved bits
// - Start offset 0..31 bytes into data area
// - Bit 13 marks opening segment
// - Bit 12 marks closing segment
// - Bits 10:0 give buffer byte count
// - Offset, count and alignment give padding dwords
// - Sum buffer sizes, restart at opening segment
// - Sum differs from packet length: raise error
// - Counts exclude offset and padding bytes
// - Packet length is second word bits 10:0
// - Offset low bits pick first byte lane
// - Host sends first word, second word, payload
`timescale 1ns/1ps
module txb_dev_end
    import txb_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    // Link from the host
    txb_if.dev              link,
    // Payload byte stream
    output logic [7:0]      o_byte_data,
    output logic            o_byte_valid,
    output logic            o_opening_segment_marker,
    output logic            o_closing_segment_marker,
    input  wire logic       i_byte_ready,
    // Status flags
    output logic            o_tx_buffer_done_flag,
    output logic            o_transmitter_error_flag,
    input  wire logic       i_err_clear
);
    typedef enum logic [1:0] {D_CMDA, D_CMDB, D_BODY} txb_dstate_t;

    typedef struct packed {
        txb_dstate_t       st;
        logic              irq;
        logic [1:0]        align;
        logic [OFF_W-1:0]  off;
        logic              first;
        logic              last;
        logic [SIZE_W-1:0] size;
        logic [SIZE_W-1:0] len;
        logic [31:0]       b_word;
        logic              in_pkt;
        logic [DWC_W-1:0]  ndw;
        logic [DWC_W-1:0]  tdw;
        logic [DWC_W-1:0]  dwc;
        logic [31:0]       word;
        logic              have;
        logic [1:0]        lane;
        logic [SUM_W-1:0]  sum;
        logic [7:0]        bdata;
        logic              bvalid;
        logic              bfirst;
        logic              blast;
        logic              done;
        logic              err;
    } txb_dev_st_t;

    txb_dev_st_t       r;
    txb_dev_st_t       n;
    logic              f_valid;
    logic [31:0]       f_data;
    logic              pop;
    logic              can_emit;
    logic              pay_byte;
    logic              step;
    logic [14:0]       idx;
    logic [14:0]       pay_end;
    logic [OFF_W-1:0]  a_off;
    logic [SIZE_W-1:0] a_size;
    logic [1:0]        a_align;
    logic [DWC_W-1:0]  a_ndw;

    // Back-pressure from the byte stream stalls draining, so the FIFO fills
    txb_fifo
    #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    )
    txb_fifo_inst
    (
        .i_clk_sys   (i_clk_sys),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (link.valid),
        .i_in_data   (link.data),
        .o_in_ready  (link.ready),
        .o_out_valid (f_valid),
        .o_out_data  (f_data),
        .i_out_ready (pop)
    );

    assign o_byte_data              = r.bdata;
    assign o_byte_valid             = r.bvalid;
    assign o_opening_segment_marker = r.bfirst;
    assign o_closing_segment_marker = r.blast;
    assign o_tx_buffer_done_flag    = r.done;
    assign o_transmitter_error_flag = r.err;

    always_comb
    begin
        n        = r;
        pop      = 1'b0;
        step     = 1'b0;
        n.done   = 1'b0;
        a_off    = f_data[A_OFF_LSB +: OFF_W];
        a_size   = f_data[A_SIZE_LSB +: SIZE_W];
        a_align  = f_data[A_ALIGN_LSB +: ALIGN_W];
        a_ndw    = txb_data_dwords(a_off, a_size);
        idx      = {r.dwc[12:0], r.lane};
        pay_end  = 15'(r.off) + 15'(r.size);
        pay_byte = (idx >= 15'(r.off)) && (idx < pay_end);
        can_emit = !r.bvalid || i_byte_ready;
        if (r.bvalid && i_byte_ready)
        begin
            n.bvalid = 1'b0;
        end
        // Clear first, so an error raised in the same cycle survives
        if (i_err_clear)
        begin
            n.err = 1'b0;
        end
        case (r.st)
            D_CMDA:
            begin
                if (f_valid)
                begin
                    pop     = 1'b1;
                    n.irq   = f_data[A_IRQ_BIT];
                    n.first = f_data[A_FIRST_BIT];
                    n.last  = f_data[A_LAST_BIT];
                    n.off   = a_off;
                    n.size  = a_size;
                    n.align = a_align;
                    n.ndw   = a_ndw;
                    n.tdw   = txb_total_dwords(a_ndw, a_align);
                    if (a_align == ALIGN_RSVD)
                    begin
                        n.err = 1'b1;
                    end
                    // Segment markers out of order leave the sum meaningless
                    if (f_data[A_FIRST_BIT] == r.in_pkt)
                    begin
                        n.err = 1'b1;
                    end
                    if (f_data[A_FIRST_BIT])
                    begin
                        n.sum = SUM_W'(a_size);
                    end
                    else
                    begin
                        n.sum = r.sum + SUM_W'(a_size);
                    end
                    n.in_pkt = !f_data[A_LAST_BIT];
                    n.st     = D_CMDB;
                end
            end
            D_CMDB:
            begin
                if (f_valid)
                begin
                    pop      = 1'b1;
                    n.len    = f_data[B_LEN_LSB +: SIZE_W];
                    n.b_word = f_data;
                    // Second word must repeat for every buffer of a packet
                    if (!r.first && (f_data != r.b_word))
                    begin
                        n.err = 1'b1;
                    end
                    n.dwc  = DWC_RST;
                    n.have = 1'b0;
                    n.lane = 2'h0;
                    n.st   = D_BODY;
                end
            end
            D_BODY:
            begin
                if (r.have)
                begin
                    if (!pay_byte)
                    begin
                        step = 1'b1;
                    end
                    else if (can_emit)
                    begin
                        step     = 1'b1;
                        n.bvalid = 1'b1;
                        n.bdata  = r.word[{r.lane, 3'b000} +: 8];
                        n.bfirst = r.first && (idx == 15'(r.off));
                        n.blast  = r.last && (idx == pay_end - 15'h0001);
                    end
                    if (step)
                    begin
                        n.lane = r.lane + 2'h1;
                        if (r.lane == 2'h3)
                        begin
                            n.have = 1'b0;
                            n.dwc  = r.dwc + 1'b1;
                        end
                    end
                end
                else if (r.dwc == r.tdw)
                begin
                    n.done = r.irq;
                    if (r.last && (r.sum != SUM_W'(r.len)))
                    begin
                        n.err = 1'b1;
                    end
                    n.st = D_CMDA;
                end
                else if (f_valid)
                begin
                    pop = 1'b1;
                    if (r.dwc < r.ndw)
                    begin
                        n.word = f_data;
                        n.have = 1'b1;
                        n.lane = 2'h0;
                    end
                    else
                    begin
                        n.dwc = r.dwc + 1'b1;
                    end
                end
            end
            default:
            begin
                n.st = D_CMDA;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            r     <= '0;
            r.err <= FLAG_RST;
            r.sum <= SUM_RST;
        end
        else
        begin
            r <= n;
        end
    end
endmodule // txb_dev_end

// [include/txb_pkg.sv]
// Shared constants, field layout and helpers for the transmit buffer link
package txb_pkg;

    // Link word and fixed buffer depth
    localparam int DATA_W     = 32;
    localparam int FIFO_DEPTH = 16;

    // First command word fields
    localparam int A_IRQ_BIT   = 31;
    localparam int A_ALIGN_LSB = 24;
    localparam int A_OFF_LSB   = 16;
    localparam int A_FIRST_BIT = 13;
    localparam int A_LAST_BIT  = 12;
    localparam int A_SIZE_LSB  = 0;

    // Second command word fields
    localparam int B_LEN_LSB = 0;

    // Field widths
    localparam int ALIGN_W = 2;
    localparam int OFF_W   = 5;
    localparam int SIZE_W  = 11;
    localparam int DWC_W   = 13;
    localparam int SUM_W   = 16;

    // Reserved bits of both command words, forced to zero by the host
    localparam logic [31:0] A_RSVD_MASK = 32'h7CE0_C800;
    localparam logic [31:0] B_RSVD_MASK = 32'h0000_C800;

    // End alignment codes
    localparam logic [1:0] ALIGN_4    = 2'h0;
    localparam logic [1:0] ALIGN_16   = 2'h1;
    localparam logic [1:0] ALIGN_32   = 2'h2;
    localparam logic [1:0] ALIGN_RSVD = 2'h3;

    // Values after reset
    localparam logic             FLAG_RST = 1'b0;
    localparam logic [DWC_W-1:0] DWC_RST  = 13'h0000;
    localparam logic [SUM_W-1:0] SUM_RST  = 16'h0000;

    // Dword mask of an alignment code; reserved code falls back to 4 bytes
    function automatic logic [2:0] txb_align_mask(input logic [1:0] code);
        logic [2:0] m;
        m = 3'h0;
        case (code)
            ALIGN_16: m = 3'h3;
            ALIGN_32: m = 3'h7;
            default:  m = 3'h0;
        endcase
        return m;
    endfunction

    // Dwords holding offset plus payload
    function automatic logic [DWC_W-1:0] txb_data_dwords(
        input logic [OFF_W-1:0]  off,
        input logic [SIZE_W-1:0] size
    );
        logic [DWC_W-1:0] s;
        s = DWC_W'(off) + DWC_W'(size) + 13'h0003;
        return {2'b00, s[DWC_W-1:2]};
    endfunction

    // Dwords including end padding up to the alignment boundary
    function automatic logic [DWC_W-1:0] txb_total_dwords(
        input logic [DWC_W-1:0] ndw,
        input logic [1:0]       code
    );
        logic [DWC_W-1:0] m;
        m = {10'h000, txb_align_mask(code)};
        return (ndw + m) & ~m;
    endfunction

endpackage

// [include/txb_if.sv]
// Dword write link from the host into the device transmit FIFO
`timescale 1ns/1ps
interface txb_if;
    logic [31:0] data;
    logic        valid;
    logic        ready;

    modport host (output data, output valid, input ready);
    modport dev  (input data, input valid, output ready);
endinterface

// [src/txb_fifo.sv]
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ps
module txb_fifo
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_arst_n,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          full;
        logic          empty;
    } txb_fifo_st_t;

    txb_fifo_st_t     r;
    txb_fifo_st_t     n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign o_in_ready  = ~r.full;
    assign o_out_valid = ~r.empty;
    assign o_out_data  = mem[r.rp];

    always_comb
    begin
        n    = r;
        push = i_in_valid & ~r.full;
        pop  = i_out_ready & ~r.empty;
        if (push)
        begin
            n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
        end
        if (pop)
        begin
            n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
        end
        n.cnt   = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        n.full  = (n.cnt == (AW+1)'(DEPTH));
        n.empty = (n.cnt == '0);
    end

    // Storage has no reset; the counter alone says what is valid
    always_ff @(posedge i_clk_sys)
    begin
        if (push)
        begin
            mem[r.wp] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            r       <= '0;
            r.empty <= 1'b1;
        end
        else
        begin
            r <= n;
        end
    end
endmodule // txb_fifo

// [src/txb_host_end.sv]
// Host end: writes command words, payload and end padding into the link
`timescale 1ns/1ps
module txb_host_end
    import txb_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    // Link towards the device
    txb_if.host              link,
    // Buffer command from the user
    input  wire logic        i_cmd_valid,
    input  wire logic [31:0] i_cmd_a,
    input  wire logic [31:0] i_cmd_b,
    output logic             o_cmd_ready,
    // Payload dwords, offset bytes included
    input  wire logic        i_pay_valid,
    input  wire logic [31:0] i_pay_data,
    output logic             o_pay_ready
);
    typedef enum logic [2:0] {H_IDLE, H_A, H_B, H_DATA, H_PAD} txb_hstate_t;

    typedef struct packed {
        txb_hstate_t      st;
        logic [31:0]      a;
        logic [31:0]      b;
        logic [DWC_W-1:0] left;
        logic [DWC_W-1:0] pad;
        logic [31:0]      ldata;
        logic             lvalid;
        logic             cmd_rdy;
        logic             pay_rdy;
    } txb_host_st_t;

    txb_host_st_t     r;
    txb_host_st_t     n;
    logic [DWC_W-1:0] ndw;
    logic [DWC_W-1:0] tdw;
    logic [31:0]      a_clean;

    assign link.data   = r.ldata;
    assign link.valid  = r.lvalid;
    assign o_cmd_ready = r.cmd_rdy;
    assign o_pay_ready = r.pay_rdy;

    always_comb
    begin
        n       = r;
        a_clean = i_cmd_a & ~A_RSVD_MASK;
        ndw     = txb_data_dwords(a_clean[A_OFF_LSB +: OFF_W],
                                  a_clean[A_SIZE_LSB +: SIZE_W]);
        tdw     = txb_total_dwords(ndw, a_clean[A_ALIGN_LSB +: ALIGN_W]);
        if (r.lvalid && link.ready)
        begin
            n.lvalid = 1'b0;
        end
        case (r.st)
            H_IDLE:
            begin
                if (r.cmd_rdy && i_cmd_valid)
                begin
                    n.a    = a_clean;
                    n.b    = i_cmd_b & ~B_RSVD_MASK;
                    n.left = ndw;
                    n.pad  = tdw - ndw;
                    n.st   = H_A;
                end
            end
            H_A:
            begin
                if (!n.lvalid)
                begin
                    n.ldata  = r.a;
                    n.lvalid = 1'b1;
                    n.st     = H_B;
                end
            end
            H_B:
            begin
                if (!n.lvalid)
                begin
                    n.ldata  = r.b;
                    n.lvalid = 1'b1;
                    n.st     = H_DATA;
                end
            end
            H_DATA:
            begin
                if (r.left == '0)
                begin
                    n.st = H_PAD;
                end
                else if (r.pay_rdy && i_pay_valid)
                begin
                    n.ldata  = i_pay_data;
                    n.lvalid = 1'b1;
                    n.left   = r.left - 1'b1;
                end
            end
            H_PAD:
            begin
                if (r.pad == '0)
                begin
                    n.st = H_IDLE;
                end
                else if (!n.lvalid)
                begin
                    n.ldata  = 32'h0000_0000;
                    n.lvalid = 1'b1;
                    n.pad    = r.pad - 1'b1;
                end
            end
            default:
            begin
                n.st = H_IDLE;
            end
        endcase
        // Half rate on payload keeps the link register free of a skid stage
        n.cmd_rdy = (n.st == H_IDLE);
        n.pay_rdy = (n.st == H_DATA) && !n.lvalid && (n.left != '0);
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end
endmodule // txb_host_end

// [testbench/txb_link_monitor.sv]
// Link checker: command word layout, handshake holding, FIFO backpressure
`timescale 1ns/1ps
module txb_link_monitor
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    // Link signals
    input  wire logic [31:0] i_data,
    input  wire logic        i_valid,
    input  wire logic        i_ready
);
    logic        take;
    logic [1:0]  ph_r;
    logic [31:0] a_r;
    logic [12:0] rem_r;
    logic [12:0] ndw;
    logic [12:0] msk;
    logic [12:0] tot;
    logic [4:0]  push_r;

    assign take = i_valid & i_ready;
    assign ndw  = (13'(a_r[20:16]) + 13'(a_r[10:0]) + 13'h0003) >> 2;
    assign msk  = (a_r[25:24] == 2'h1) ? 13'h0003 :
                  (a_r[25:24] == 2'h2) ? 13'h0007 : 13'h0000;
    assign tot  = (ndw + msk) & ~msk;

    // Word position tracking; phase 0 is command A, 1 command B, 2 data
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            ph_r   <= 2'h0;
            a_r    <= 32'h0000_0000;
            rem_r  <= 13'h0000;
            push_r <= 5'h00;
        end
        else if (take)
        begin
            // Saturates: only the first fill can be judged without pops
            push_r <= (push_r == 5'h10) ? push_r : push_r + 5'h01;
            if (ph_r == 2'h0)
            begin
                a_r  <= i_data;
                ph_r <= 2'h1;
            end
            else if (ph_r == 2'h1)
            begin
                rem_r <= tot;
                ph_r  <= (tot == 13'h0000) ? 2'h0 : 2'h2;
            end
            else
            begin
                rem_r <= rem_r - 13'h0001;
                ph_r  <= (rem_r == 13'h0001) ? 2'h0 : 2'h2;
            end
        end
    end

    sequence s_take_a;
        take && ph_r == 2'h0;
    endsequence
    sequence s_take_b;
        take && ph_r == 2'h1;
    endsequence
    sequence s_stall;
        i_valid && !i_ready;
    endsequence

    AST_RSVD_A:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            s_take_a |-> (i_data & 32'h7CE0_C800) == 32'h0000_0000)
        else $error("reserved bits set in first command word");
    AST_RSVD_B:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            s_take_b |-> i_data[15:14] == 2'h0 && !i_data[11])
        else $error("reserved bits set in second command word");
    AST_VALID_HOLD:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            s_stall |=> i_valid)
        else $error("valid dropped before the word was taken");
    AST_DATA_HOLD:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            s_stall |=> $stable(i_data))
        else $error("data changed before the word was taken");
    AST_B_AFTER_A:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            s_take_a |=> i_valid)
        else $error("second command word not offered after the first");
    AST_READY_RST:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            $rose(i_arst_n) |-> i_ready)
        else $error("link not ready after reset");
    AST_VALID_RST:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            $rose(i_arst_n) |-> !i_valid ##1 !i_valid)
        else $error("link word offered too early after reset");
    AST_FULL_ONLY:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            !i_ready |-> push_r == 5'h10)
        else $error("link refused before sixteen words were pushed");
    AST_FALL_ON_PUSH:
        assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
            $fell(i_ready) |-> $past(take))
        else $error("ready fell without a push");
endmodule // txb_link_monitor

// [testbench/tx_buffer_command_decoder_bench.sv]
// Bench joining host and device ends over the link, checking bytes and flags
`timescale 1ns/1ps
module tx_buffer_command_decoder_bench import txb_pkg::*;;
    logic        i_clk_sys;
    logic        i_arst_n;
    logic        cmd_valid, cmd_ready, pay_valid, pay_ready;
    logic [31:0] cmd_a, cmd_b, pay_data;
    logic [7:0]  byte_data;
    logic        byte_valid, open_m, close_m, byte_ready;
    logic        done, err, err_clear, stall;
    logic [31:0] seed = 32'h6fd3_478d;
    logic [9:0]  exq[$];
    logic [9:0]  e;
    logic [31:0] sr;
    int          fails = 0;
    int          cmp_count = 0;
    int          done_cnt = 0;
    int          done_exp = 0;
    logic [1:0]  t_al[5] = '{ALIGN_4, ALIGN_16, ALIGN_32, ALIGN_16, ALIGN_32};
    logic [4:0]  t_off[5] = '{5'h1F, 5'h05, 5'h02, 5'h00, 5'h07};
    logic [10:0] t_sz[5] = '{11'h001, 11'h009, 11'h021, 11'h010, 11'h003};

    txb_if link ();
    txb_host_end txb_host_end_inst (.i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n), .link(link), .i_cmd_valid(cmd_valid),
        .i_cmd_a(cmd_a), .i_cmd_b(cmd_b), .o_cmd_ready(cmd_ready),
        .i_pay_valid(pay_valid), .i_pay_data(pay_data),
        .o_pay_ready(pay_ready));
    txb_dev_end txb_dev_end_inst (.i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n), .link(link), .o_byte_data(byte_data),
        .o_byte_valid(byte_valid), .o_opening_segment_marker(open_m),
        .o_closing_segment_marker(close_m), .i_byte_ready(byte_ready),
        .o_tx_buffer_done_flag(done), .o_transmitter_error_flag(err),
        .i_err_clear(err_clear));
    txb_link_monitor txb_link_monitor_inst (.i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n), .i_data(link.data), .i_valid(link.valid),
        .i_ready(link.ready));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic timeout(input string what);
        fails++;
        $display("BAD %s exp handshake seen timeout", what);
        tally_and_finish();
    endtask

    // One buffer: command pair, then offset and payload dwords
    task automatic run_buf(input logic irq, input logic [1:0] al,
        input logic [4:0] off, input logic [10:0] sz, input logic fs,
        input logic ls, input logic [10:0] len);
        logic [31:0] w;
        logic [31:0] r;
        int          nb;
        int          idx;
        int          t;
        nb = int'(off) + int'(sz);
        r = rnd();
        cmd_a <= {irq, 5'h00, al, 3'h0, off, 2'h0, fs, ls, 1'b0, sz}
                 | (r & A_RSVD_MASK);
        cmd_b <= {16'hA5C3, 5'h00, len} | (r & B_RSVD_MASK);
        cmd_valid <= 1'b1;
        t = 0;
        do begin @(posedge i_clk_sys); t++; end
        while (cmd_ready !== 1'b1 && t < 3000);
        cmd_valid <= 1'b0;
        if (t == 3000) timeout("command");
        for (int i = 0; i < (nb + 3) / 4; i++)
        begin
            // Bytes past the size are random so leaks are visible
            for (int k = 0; k < 4; k++)
            begin
                idx = i * 4 + k;
                r = rnd();
                w[8*k +: 8] = r[7:0];
                if (idx >= int'(off) && idx < nb)
                    exq.push_back({ls && idx == nb - 1,
                                   fs && idx == int'(off), r[7:0]});
            end
            pay_data <= w;
            pay_valid <= 1'b1;
            t = 0;
            do begin @(posedge i_clk_sys); t++; end
            while (pay_ready !== 1'b1 && t < 3000);
            if (t == 3000) timeout("payload");
        end
        pay_valid <= 1'b0;
    endtask

    task automatic end_test(input string name, input logic exp_err,
                            input int ndone);
        int t;
        t = 0;
        done_exp += ndone;
        do begin @(posedge i_clk_sys); t++; end
        while (!(exq.size() == 0 && cmd_ready === 1'b1) && t < 5000);
        if (t == 5000) timeout(name);
        repeat (16) @(posedge i_clk_sys);
        check("error", err, exp_err);
        check("done", done_cnt, done_exp);
        err_clear <= 1'b1;
        @(posedge i_clk_sys);
        err_clear <= 1'b0;
        @(posedge i_clk_sys);
        check("error_cleared", err, 1'b0);
        $display("test %s ended", name);
    endtask

    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    // Sink stalls at random; held off entirely while the FIFO is filled
    always @(posedge i_clk_sys)
    begin
        sr = rnd();
        byte_ready <= stall ? 1'b0 : (sr[1:0] != 2'b00);
    end

    always @(posedge i_clk_sys)
    begin
        if (i_arst_n === 1'b1 && done === 1'b1)
            done_cnt <= done_cnt + 1;
        if (i_arst_n === 1'b1 && byte_valid === 1'b1 && byte_ready === 1'b1)
        begin
            e = 'x;
            if (exq.size() > 0)
                e = exq.pop_front();
            check("byte", byte_data, e[7:0]);
            check("opening", open_m, e[8]);
            check("closing", close_m, e[9]);
        end
    end

    initial
    begin
        int t;
        logic [31:0] r;
        cmd_valid = 1'b0;
        cmd_a = 32'h0000_0000;
        cmd_b = 32'h0000_0000;
        pay_valid = 1'b0;
        pay_data = 32'h0000_0000;
        byte_ready = 1'b0;
        err_clear = 1'b0;
        stall = 1'b0;
        i_arst_n = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        run_buf(1'b1, ALIGN_4, 5'h00, 11'h005, 1'b1, 1'b1, 11'h005);
        end_test("single", 1'b0, 1);
        for (int i = 0; i < 5; i++)
            run_buf(i[0], t_al[i], t_off[i], t_sz[i], 1'b1, 1'b1, t_sz[i]);
        end_test("align", 1'b0, 2);
        run_buf(1'b1, ALIGN_16, 5'h03, 11'h006, 1'b1, 1'b0, 11'h00F);
        run_buf(1'b0, ALIGN_32, 5'h06, 11'h004, 1'b0, 1'b0, 11'h00F);
        run_buf(1'b1, ALIGN_4, 5'h01, 11'h005, 1'b0, 1'b1, 11'h00F);
        end_test("multi", 1'b0, 2);
        run_buf(1'b0, ALIGN_4, 5'h00, 11'h006, 1'b1, 1'b0, 11'h00C);
        run_buf(1'b0, ALIGN_32, 5'h00, 11'h007, 1'b0, 1'b1, 11'h00C);
        end_test("length", 1'b1, 0);
        run_buf(1'b0, ALIGN_RSVD, 5'h02, 11'h00B, 1'b1, 1'b1, 11'h00B);
        end_test("reserved_align", 1'b1, 0);
        run_buf(1'b0, ALIGN_4, 5'h00, 11'h004, 1'b0, 1'b1, 11'h004);
        end_test("orphan", 1'b1, 0);
        stall = 1'b1;
        fork
            run_buf(1'b0, ALIGN_4, 5'h00, 11'h064, 1'b1, 1'b1, 11'h064);
            begin
                t = 0;
                do begin @(posedge i_clk_sys); t++; end
                while (link.ready !== 1'b0 && t < 3000);
                check("link_full", link.ready, 1'b0);
                stall = 1'b0;
            end
        join
        end_test("fifo", 1'b0, 0);
        check("link_drained", link.ready, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            r = rnd();
            run_buf(r[31], 2'(r[9:8] % 3), r[20:16], 11'(r[5:0]) + 11'h001,
                    1'b1, 1'b1, 11'(r[5:0]) + 11'h001);
            if (r[31]) done_exp++;
        end
        end_test("random", 1'b0, 0);
        tally_and_finish();
    end
endmodule // tx_buffer_command_decoder_bench
